// file: logic/tsf_checker.sv
`timescale 1ns/100ps
`default_nettype none
module tsf_checker
  import tsf_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          req_valid,
  input  wire tsf_req_type   req,
  output logic               req_ready,
  output logic               busy,
  output logic               tr_load_r,
  output logic               link_write_r,
  output logic               seg_load_r,
  output logic               done_r,
  output logic               fault_r,
  output tsf_fault_type      fault_info_r
);

  typedef enum logic [2:0] {
    TSF_S_IDLE,
    TSF_S_CHECK,
    TSF_S_LOAD,
    TSF_S_VALID
  } tsf_state_type;

  tsf_state_type state_r;
  tsf_state_type state_nxt;
  tsf_req_type   req_r;
  logic [2:0]    vstep_r;
  logic          pre_bad;
  logic          val_bad;
  logic [15:0]   val_sel;
  logic          is_interrupt_return;
  logic          is_ltr;
  logic          new_null;
  logic          lim_small;
  logic          reloaded_r;
  logic [TSF_NUM_DATA-1:0] data_bad;

  assign req_ready = (state_r == TSF_S_IDLE);
  assign busy      = !req_ready;
  assign is_interrupt_return   = (req_r.kind == TSF_INTERRUPT_RETURN);
  assign is_ltr    = (req_r.kind == TSF_LTR);
  assign new_null  = (req_r.new_tss.sel[15:2] == 14'h0);
  assign lim_small = req_r.tss_32 ? (req_r.tss_limit < TSF_MIN_LIM32)
                                  : (req_r.tss_limit < TSF_MIN_LIM16);

  // Terms are OR-ed; whichever holds, the fault reports the new task segment selector
  always_comb begin
    pre_bad = 1'b0;
    if (is_ltr) begin
      pre_bad = new_null || req_r.new_tss.sel[TSF_TI_BIT]
             || !req_r.new_tss.in_limit
             || (req_r.new_tss.typ != TSF_TYP_AVL32
                 && req_r.new_tss.typ != TSF_TYP_AVL16);
    end else if (is_interrupt_return) begin
      pre_bad = req_r.new_tss.sel[TSF_TI_BIT] || !req_r.new_tss.in_limit
             || req_r.link_load_fault || new_null
             || (req_r.new_tss.typ != TSF_TYP_BSY32
                 && req_r.new_tss.typ != TSF_TYP_BSY16);
    end else begin
      pre_bad = new_null || req_r.new_tss.sel[TSF_TI_BIT]
             || (req_r.new_tss.typ != TSF_TYP_AVL32
                 && req_r.new_tss.typ != TSF_TYP_AVL16)
             || !req_r.new_tss.in_limit;
    end
    if (!is_ltr) begin
      pre_bad = pre_bad || !req_r.new_tss_wr || req_r.old_store_fault;
      pre_bad = pre_bad || (req_r.kind == TSF_JMP && !req_r.old_tss_wr)
             || (is_interrupt_return && !req_r.old_tss_wr)
             || ((req_r.kind == TSF_CALL || req_r.kind == TSF_EXC)
                 && !req_r.link_wr);
    end
    pre_bad = pre_bad || lim_small;
  end

  // Null data selectors are legal; they only fault when used
  generate
    for (genvar g = 0; g < TSF_NUM_DATA; g++) begin : g_data
      tsf_seg_type d;
      logic        code;
      assign d    = req_r.data[g];
      assign code = d.typ[TSF_TYP_CODE];
      assign data_bad[g] = (d.sel[15:2] != 14'h0)
        && (!d.in_limit || !d.s_bit
            || (code && !d.typ[TSF_TYP_RW])
            || (code && !d.typ[TSF_TYP_CONF]
                && (d.sel[1:0] > d.descriptor_privilege || req_r.current_privilege > d.descriptor_privilege)));
    end
  endgenerate

  // One selector per cycle; the step restarts in the load state and advances every validation cycle
  always_comb begin
    val_bad = 1'b0;
    val_sel = 16'h0000;
    unique case (vstep_r)
      3'h0: begin
        val_sel = req_r.local_descriptor_table.sel;
        val_bad = (req_r.local_descriptor_table.sel[15:2] != 14'h0)
               && (!req_r.local_descriptor_table.in_limit || req_r.local_descriptor_table.s_bit
                   || req_r.local_descriptor_table.typ != TSF_TYP_LDT || !req_r.local_descriptor_table.present);
      end
      TSF_STEP_SS: begin
        val_sel = req_r.ss.sel;
        val_bad = !req_r.ss.in_limit || req_r.ss.sel[15:2] == 14'h0
               || !req_r.ss.s_bit || req_r.ss.typ[TSF_TYP_CODE]
               || !req_r.ss.typ[TSF_TYP_RW] || req_r.ss.descriptor_privilege != req_r.current_privilege
               || req_r.ss.sel[1:0] != req_r.current_privilege;
      end
      TSF_STEP_CS: begin
        val_sel = req_r.cs.sel;
        val_bad = !req_r.cs.in_limit || req_r.cs.sel[15:2] == 14'h0
               || !req_r.cs.s_bit || !req_r.cs.typ[TSF_TYP_CODE]
               || (!req_r.cs.typ[TSF_TYP_CONF] && req_r.cs.descriptor_privilege != req_r.current_privilege)
               || (req_r.cs.typ[TSF_TYP_CONF] && req_r.cs.descriptor_privilege > req_r.current_privilege);
      end
      default: begin
        val_sel = req_r.data[2'(vstep_r - TSF_STEP_DAT)].sel;
        val_bad = data_bad[2'(vstep_r - TSF_STEP_DAT)];
      end
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      TSF_S_IDLE:  if (req_valid) state_nxt = TSF_S_CHECK;
      TSF_S_CHECK: state_nxt = (pre_bad || is_ltr) ? TSF_S_IDLE : TSF_S_LOAD;
      TSF_S_LOAD:  state_nxt = TSF_S_VALID;
      TSF_S_VALID: if (val_bad || vstep_r == TSF_STEP_LAST) state_nxt = TSF_S_IDLE;
      default:     state_nxt = TSF_S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= TSF_S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Snapshot held for the whole sequence so late checks see a stable view
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      req_r <= '0;
    end else if (req_valid && req_ready) begin
      req_r <= req;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      vstep_r <= 3'h0;
    end else if (state_r == TSF_S_LOAD) begin
      vstep_r <= 3'h0;
    end else if (state_r == TSF_S_VALID) begin
      vstep_r <= vstep_r + 3'h1;
    end
  end

  // Commit point: nothing visible changes unless the early checks all pass
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tr_load_r    <= 1'b0;
      link_write_r <= 1'b0;
    end else begin
      tr_load_r    <= (state_r == TSF_S_CHECK) && !pre_bad;
      link_write_r <= (state_r == TSF_S_CHECK) && !pre_bad
                   && (req_r.kind == TSF_CALL || req_r.kind == TSF_EXC);
    end
  end

  // Every register is reloaded in the same cycle as the first validation step
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seg_load_r <= 1'b0;
    end else begin
      seg_load_r <= (state_r == TSF_S_LOAD);
    end
  end

  // Remembers the reload so a late fault can be tied to it; cleared when a new request is taken
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reloaded_r <= 1'b0;
    end else if (req_valid && req_ready) begin
      reloaded_r <= 1'b0;
    end else if (seg_load_r) begin
      reloaded_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= ((state_r == TSF_S_CHECK) && !pre_bad && is_ltr)
             || ((state_r == TSF_S_VALID) && !val_bad
                 && vstep_r == TSF_STEP_LAST);
    end
  end

  // Validation stops at the first bad selector; the rest stay loaded unchecked
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault_r      <= 1'b0;
      fault_info_r <= '0;
    end else begin
      fault_r <= 1'b0;
      if (state_r == TSF_S_CHECK && pre_bad) begin
        fault_r               <= 1'b1;
        fault_info_r.vector   <= TSF_VECTOR;
        fault_info_r.err_code <= {req_r.new_tss.sel[15:2], 1'b0, req_r.external_cause_flag};
        fault_info_r.ctx_new  <= 1'b0;
        fault_info_r.eip_new  <= 1'b0;
        fault_info_r.escalate <= req_r.prior_contrib;
      end else if (state_r == TSF_S_VALID && val_bad) begin
        fault_r               <= 1'b1;
        fault_info_r.vector   <= TSF_VECTOR;
        fault_info_r.err_code <= {val_sel[15:2], 1'b0, req_r.external_cause_flag};
        fault_info_r.ctx_new  <= 1'b1;
        fault_info_r.eip_new  <= 1'b1;
        fault_info_r.escalate <= req_r.prior_contrib;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_pre_fail;
    state_r == TSF_S_CHECK && pre_bad;
  endsequence

  sequence s_commit;
    tr_load_r && !is_ltr;
  endsequence

  a_fault_vector: assert property (fault_r |-> fault_info_r.vector == TSF_VECTOR)
    else $error("fault raised with wrong vector");

  a_limit_short: assert property (state_r == TSF_S_CHECK && !req_r.tss_32
    && req_r.tss_limit < TSF_MIN_LIM16 |=> fault_r && !tr_load_r)
    else $error("short task segment limit not faulted");

  a_ltr_null: assert property (state_r == TSF_S_CHECK && is_ltr && new_null
    |=> fault_r && fault_info_r.err_code[15:3] == $past(req_r.new_tss.sel[15:3]))
    else $error("null selector on register load not faulted");

  // Register load commits without touching the segment registers
  a_ltr_commit: assert property (state_r == TSF_S_CHECK && is_ltr && !pre_bad
    |=> tr_load_r && done_r && !link_write_r ##1 !seg_load_r)
    else $error("register load reloaded segments or did not finish");

  a_pre_old_ctx: assert property (s_pre_fail |=> fault_r && !fault_info_r.ctx_new
    && !tr_load_r && !link_write_r ##1 !seg_load_r)
    else $error("early fault changed state or used new context");

  a_link_pair: assert property (link_write_r |-> tr_load_r
    && (req_r.kind == TSF_CALL || req_r.kind == TSF_EXC))
    else $error("link written without task register load");

  a_ext_flag: assert property (fault_r |-> fault_info_r.err_code[0] == req_r.external_cause_flag
    && fault_info_r.escalate == req_r.prior_contrib)
    else $error("external flag or escalation mismatch");

  a_eip_ctx: assert property (fault_r |-> fault_info_r.eip_new == fault_info_r.ctx_new
    && fault_info_r.ctx_new == reloaded_r)
    else $error("saved pointer and context disagree");

  a_load_first: assert property (s_commit |=> seg_load_r && !fault_r ##[1:7] (fault_r || done_r))
    else $error("segment load and validation out of order");

  a_late_new_ctx: assert property (fault_r && fault_info_r.ctx_new |-> reloaded_r)
    else $error("late fault without prior reload");

  // A request taken in the fault cycle is legal, so the next state may already be the check
  a_one_fault: assert property (fault_r |-> !done_r ##1 !fault_r && !done_r
    && (state_r == TSF_S_IDLE || state_r == TSF_S_CHECK))
    else $error("more than one condition reported");

endmodule
`default_nettype wire

// file: logic/tsf_pkg.sv
`default_nettype none
package tsf_pkg;
  localparam logic [7:0]  TSF_VECTOR    = 8'h0a;
  localparam logic [19:0] TSF_MIN_LIM32 = 20'h00067;
  localparam logic [19:0] TSF_MIN_LIM16 = 20'h0002c;
  localparam logic [3:0]  TSF_TYP_AVL16 = 4'h1;
  localparam logic [3:0]  TSF_TYP_LDT   = 4'h2;
  localparam logic [3:0]  TSF_TYP_BSY16 = 4'h3;
  localparam logic [3:0]  TSF_TYP_AVL32 = 4'h9;
  localparam logic [3:0]  TSF_TYP_BSY32 = 4'hb;
  localparam int          TSF_TI_BIT    = 2;
  localparam int          TSF_TYP_CODE  = 3;
  localparam int          TSF_TYP_CONF  = 2;
  localparam int          TSF_TYP_RW    = 1;
  localparam int          TSF_NUM_DATA  = 4;
  localparam logic [2:0]  TSF_STEP_SS   = 3'h1;
  localparam logic [2:0]  TSF_STEP_CS   = 3'h2;
  localparam logic [2:0]  TSF_STEP_DAT  = 3'h3;
  localparam logic [2:0]  TSF_STEP_LAST = 3'h6;

  typedef enum logic [2:0] {
    TSF_JMP,
    TSF_CALL,
    TSF_INTERRUPT_RETURN,
    TSF_EXC,
    TSF_LTR
  } tsf_kind_type;

  // Descriptor snapshot as fetched by the core for one selector
  typedef struct packed {
    logic [15:0] sel;
    logic        in_limit;
    logic        present;
    logic        s_bit;
    logic [3:0]  typ;
    logic [1:0]  descriptor_privilege;
  } tsf_seg_type;

  typedef struct packed {
    tsf_kind_type                  kind;
    logic                          external_cause_flag;
    logic                          prior_contrib;
    logic [1:0]                    current_privilege;
    logic                          tss_32;
    logic [19:0]                   tss_limit;
    tsf_seg_type                   new_tss;
    logic                          new_tss_wr;
    logic                          old_tss_wr;
    logic                          old_store_fault;
    logic                          link_load_fault;
    logic                          link_wr;
    tsf_seg_type                   local_descriptor_table;
    tsf_seg_type                   ss;
    tsf_seg_type                   cs;
    tsf_seg_type [TSF_NUM_DATA-1:0] data;
  } tsf_req_type;

  typedef struct packed {
    logic [7:0]  vector;
    logic [15:0] err_code;
    logic        ctx_new;
    logic        eip_new;
    logic        escalate;
  } tsf_fault_type;
endpackage
`default_nettype wire

// file: testbench/tsf_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module tsf_mem_model
  import tsf_pkg::*;
(
  input  wire tsf_kind_type kind,
  output var  tsf_req_type  req_good
);
  // Tables are well formed; the bench breaks up to three fields per operation
  function automatic tsf_seg_type seg(input logic [15:0] sel, input logic s, input logic [3:0] t, input logic [1:0] d);
    seg = '{sel: sel, in_limit: 1'b1, present: 1'b1, s_bit: s, typ: t, descriptor_privilege: d};
  endfunction

  always_comb begin
    req_good            = '0;
    req_good.kind       = kind;
    req_good.tss_32     = 1'b1;
    req_good.tss_limit  = TSF_MIN_LIM32;
    req_good.new_tss    = seg(16'h0028, 1'b0, (kind == TSF_INTERRUPT_RETURN) ? TSF_TYP_BSY32 : TSF_TYP_AVL32, 2'h0);
    req_good.new_tss_wr = 1'b1;
    req_good.old_tss_wr = 1'b1;
    req_good.link_wr    = 1'b1;
    req_good.local_descriptor_table        = seg(16'h0030, 1'b0, TSF_TYP_LDT, 2'h0);
    req_good.ss         = seg(16'h0040, 1'b1, 4'h2, 2'h0);
    req_good.cs         = seg(16'h0038, 1'b1, 4'ha, 2'h0);
    for (int i = 0; i < TSF_NUM_DATA; i++) begin
      req_good.data[i] = seg(16'h0048 + 16'(i * 8), 1'b1, 4'h2, 2'h3);
    end
  end
endmodule
`default_nettype wire

// file: testbench/test_tsf_checker.sv
`timescale 1ns/100ps
`default_nettype none
module test_tsf_checker;
  import tsf_pkg::*;
  logic          clk_sys;
  logic          rst;
  logic          req_valid;
  tsf_req_type   req;
  logic          req_ready;
  logic          busy;
  logic          tr_load_r;
  logic          link_write_r;
  logic          seg_load_r;
  logic          done_r;
  logic          fault_r;
  tsf_fault_type fault_info_r;
  tsf_kind_type  kind;
  tsf_req_type   good;
  int            mismatches;
  int            checks;
  int            tn;

  tsf_checker tsf_checker_i (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .busy(busy), .tr_load_r(tr_load_r), .link_write_r(link_write_r),
    .seg_load_r(seg_load_r), .done_r(done_r), .fault_r(fault_r), .fault_info_r(fault_info_r));
  tsf_mem_model tsf_mem_model_i (.kind(kind), .req_good(good));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One operation: break field f, expect a fault on selector es or a clean finish
  task automatic sc(input tsf_kind_type k, input int f, input logic [19:0] v,
                    input logic flt, input logic [15:0] es, input logic post);
    tsf_req_type r;
    int          n;
    logic        tr;
    logic        sg;
    logic        lk;
    kind = k;
    #1;
    r = good;
    case (f)
      1: r.tss_limit = v;
      2: begin
        r.tss_32 = 1'b0;
        r.new_tss.typ = TSF_TYP_AVL16;
        r.tss_limit = v;
      end
      3: r.new_tss.sel = v[15:0];
      4: r.new_tss.typ = v[3:0];
      5: r.new_tss.in_limit = 1'b0;
      6: r.link_load_fault = 1'b1;
      7: r.new_tss_wr = 1'b0;
      8: r.old_store_fault = 1'b1;
      9: r.old_tss_wr = 1'b0;
      10: r.link_wr = 1'b0;
      11: r.local_descriptor_table.present = 1'b0;
      12: r.ss.descriptor_privilege = v[1:0];
      13: r.ss.sel = v[15:0];
      14: r.cs.typ = v[3:0];
      15: begin
        r.cs.typ = 4'he;
        r.cs.descriptor_privilege = v[1:0];
      end
      16: r.data[3].typ = v[3:0];
      17: r.data[0].in_limit = 1'b0;
      18: begin
        r.data[1].typ = 4'ha;
        r.data[1].sel = v[15:0];
        r.data[1].descriptor_privilege = 2'h0;
      end
      19: begin
        r.ss.descriptor_privilege = 2'h1;
        r.cs.typ = 4'h2;
      end
      20: begin
        r.new_tss_wr = 1'b0;
        r.external_cause_flag = 1'b1;
        r.prior_contrib = 1'b1;
      end
      default: ;
    endcase
    @(negedge clk_sys);
    req_valid = 1'b1;
    req = r;
    @(negedge clk_sys);
    // Still offered while busy, with a null selector; taking it would show
    req.new_tss.sel = 16'h0000;
    check(16'(busy), 16'h0001);
    check(16'(req_ready), 16'h0000);
    tr = 1'b0;
    sg = 1'b0;
    lk = 1'b0;
    for (n = 0; n < 24; n++) begin
      @(negedge clk_sys);
      req_valid = 1'b0;
      tr = tr | tr_load_r;
      sg = sg | seg_load_r;
      lk = lk | link_write_r;
      if (fault_r === 1'b1 || done_r === 1'b1) break;
    end
    if (n == 24) begin
      mismatches++;
      $display("mismatch at %0t: no fault or finish in time", $time);
      end_sim();
    end
    check(16'(req_ready), 16'h0001);
    check(16'(fault_r), 16'(flt));
    if (flt) begin
      check(16'(fault_info_r.vector), 16'(TSF_VECTOR));
      check(fault_info_r.err_code, {es[15:2], 1'b0, r.external_cause_flag});
      check(16'(fault_info_r.ctx_new), 16'(post));
      check(16'(fault_info_r.eip_new), 16'(post));
      check(16'(fault_info_r.escalate), 16'(r.prior_contrib));
      check(16'(tr), 16'(post));
      check(16'(sg), 16'(post));
      check(16'(lk), 16'(post && (k == TSF_CALL || k == TSF_EXC)));
    end else begin
      check(16'(tr), 16'h0001);
      check(16'(lk), 16'(k == TSF_CALL || k == TSF_EXC));
      check(16'(sg), 16'(k != TSF_LTR));
    end
    tn++;
    $display("test %0d done", tn);
  endtask

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    kind = TSF_JMP;
    mismatches = 0;
    checks = 0;
    tn = 0;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    for (int k = 0; k <= 4; k++) sc(tsf_kind_type'(3'(k)), 0, 20'h0, 0, 16'h0, 0);
    sc(TSF_JMP, 1, 20'h00066, 1, 16'h0028, 0);
    sc(TSF_JMP, 2, 20'h0002b, 1, 16'h0028, 0);
    sc(TSF_JMP, 2, 20'h0002c, 0, 16'h0, 0);
    sc(TSF_INTERRUPT_RETURN, 3, 20'h0002c, 1, 16'h002c, 0);
    sc(TSF_INTERRUPT_RETURN, 5, 20'h0, 1, 16'h0028, 0);
    sc(TSF_INTERRUPT_RETURN, 4, 20'h00009, 1, 16'h0028, 0);
    sc(TSF_INTERRUPT_RETURN, 6, 20'h0, 1, 16'h0028, 0);
    sc(TSF_INTERRUPT_RETURN, 3, 20'h00003, 1, 16'h0003, 0);
    sc(TSF_CALL, 7, 20'h0, 1, 16'h0028, 0);
    sc(TSF_JMP, 8, 20'h0, 1, 16'h0028, 0);
    sc(TSF_JMP, 9, 20'h0, 1, 16'h0028, 0);
    sc(TSF_CALL, 9, 20'h0, 0, 16'h0, 0);
    sc(TSF_CALL, 10, 20'h0, 1, 16'h0028, 0);
    sc(TSF_EXC, 10, 20'h0, 1, 16'h0028, 0);
    sc(TSF_JMP, 10, 20'h0, 0, 16'h0, 0);
    sc(TSF_EXC, 3, 20'h00000, 1, 16'h0000, 0);
    sc(TSF_JMP, 3, 20'h0002c, 1, 16'h002c, 0);
    sc(TSF_JMP, 4, 20'h0000b, 1, 16'h0028, 0);
    sc(TSF_LTR, 3, 20'h00000, 1, 16'h0000, 0);
    sc(TSF_LTR, 3, 20'h0002c, 1, 16'h002c, 0);
    sc(TSF_LTR, 5, 20'h0, 1, 16'h0028, 0);
    sc(TSF_LTR, 4, 20'h00002, 1, 16'h0028, 0);
    sc(TSF_JMP, 11, 20'h0, 1, 16'h0030, 1);
    sc(TSF_JMP, 12, 20'h00001, 1, 16'h0040, 1);
    sc(TSF_CALL, 13, 20'h00041, 1, 16'h0041, 1);
    sc(TSF_JMP, 13, 20'h00000, 1, 16'h0000, 1);
    sc(TSF_JMP, 14, 20'h00002, 1, 16'h0038, 1);
    sc(TSF_EXC, 15, 20'h00001, 1, 16'h0038, 1);
    sc(TSF_JMP, 15, 20'h00000, 0, 16'h0, 0);
    sc(TSF_JMP, 16, 20'h00008, 1, 16'h0060, 1);
    sc(TSF_INTERRUPT_RETURN, 17, 20'h0, 1, 16'h0048, 1);
    sc(TSF_JMP, 18, 20'h00053, 1, 16'h0053, 1);
    sc(TSF_JMP, 19, 20'h0, 1, 16'h0040, 1);
    sc(TSF_CALL, 20, 20'h0, 1, 16'h0028, 0);
    // Handler entered as its own task through a gate, then the switch back revalidates
    sc(TSF_EXC, 0, 20'h0, 0, 16'h0, 0);
    sc(TSF_INTERRUPT_RETURN, 12, 20'h00002, 1, 16'h0040, 1);
    end_sim();
  end
endmodule
`default_nettype wire
